// ==== fis_pkg.sv ====
// package: register map, field layout and types of the fault info / input status bank
package fis_pkg;
	localparam int FIS_ADDR_W = 6;
	localparam int FIS_HIST_DEPTH = 5;
	localparam int FIS_PSET_W = 2;
	localparam int FIS_DIN_W = 13;
	localparam int FIS_VER_W = 16;
	localparam logic [15:0] FIS_VER_MAX = 16'h270F; // 9999
	// register byte offsets
	localparam logic [FIS_ADDR_W-1:0] FIS_OFS_HIST_SEL = 6'h00;
	localparam logic [FIS_ADDR_W-1:0] FIS_OFS_HIST_DATA = 6'h04;
	localparam logic [FIS_ADDR_W-1:0] FIS_OFS_VER_SEL = 6'h08;
	localparam logic [FIS_ADDR_W-1:0] FIS_OFS_VER_DATA = 6'h0C;
	localparam logic [FIS_ADDR_W-1:0] FIS_OFS_DIN = 6'h10;
	localparam logic [FIS_ADDR_W-1:0] FIS_OFS_IRQ_STAT = 6'h14;
	localparam logic [FIS_ADDR_W-1:0] FIS_OFS_IRQ_MASK = 6'h18;
	localparam logic [FIS_ADDR_W-1:0] FIS_OFS_FAULT_CNT = 6'h1C;
	// selector fields
	localparam int FIS_SEL_IDX_LSB = 0;
	localparam int FIS_SEL_IDX_W = 3;
	localparam int FIS_SEL_CONFIRM_BIT = 8;
	// irq status bits
	localparam int FIS_IRQ_FAULT_BIT = 0;
	localparam int FIS_IRQ_DIN_BIT = 1;
	localparam int FIS_IRQ_W = 2;
	// input bitmap fields
	localparam int FIS_DIN_BASE_W = 6;
	localparam int FIS_DIN_POS_LSB = 6;
	localparam int FIS_DIN_POS_W = 6;
	localparam int FIS_DIN_ENC_BIT = 12;
	// reset values and unmapped read data
	localparam logic [2:0] FIS_SEL_RST = 3'h1;
	localparam logic [31:0] FIS_RD_UNMAPPED = 32'h0000_0000;

	typedef struct packed {
		logic read;
		logic write;
		logic [FIS_ADDR_W-1:0] address;
		logic [31:0] writedata;
	} fis_bus_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
		logic readdatavalid;
	} fis_bus_rsp_t;
endpackage

// ==== fis_bank.sv ====
// fault info / input status register bank with avalon-mm slave
`timescale 1ns/1ns
module fis_bank
	import fis_pkg::*;
#(
	parameter int HIST_DEPTH = FIS_HIST_DEPTH,
	parameter logic [15:0] VERSION_0 = 16'h0001, // arbitrary
	parameter logic [15:0] VERSION_1 = 16'h0000 // arbitrary
) (
	input wire logic clk_sys_i, // 25 MHz system clock
	input wire logic resetn_i, // async reset, active low
	input wire logic clk_en_i, // freezes all state while low
	input wire fis_bus_req_t bus_req_i, // avalon-mm request
	output fis_bus_rsp_t bus_rsp_o, // avalon-mm response
	input wire logic fault_i, // fault event pulse, same clock domain
	input wire logic [FIS_PSET_W-1:0] pset_i, // active parameter set code
	input wire logic [FIS_DIN_W-1:0] din_pins_i, // raw digital input pins
	input wire logic pos_opt_i, // positioning option fitted
	input wire logic enc_opt_i, // encoder option fitted
	output logic irq_o // level interrupt
);
	localparam logic [31:0] VER_MAX32 = {16'h0000, FIS_VER_MAX};

	// clip version to displayable range
	function automatic logic [FIS_VER_W-1:0] ver_clip(input logic [FIS_VER_W-1:0] v);
		ver_clip = (v > FIS_VER_MAX) ? FIS_VER_MAX : v;
	endfunction

	function automatic logic sel_ok(input logic [2:0] idx);
		sel_ok = (idx >= 3'h1) && (32'(idx) <= HIST_DEPTH);
	endfunction

	// pin synchronisers
	logic [FIS_DIN_W-1:0] din_s1_r, din_s2_r;
	logic [1:0] opt_s1_r, opt_s2_r;
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			din_s1_r <= '0;
			din_s2_r <= '0;
			opt_s1_r <= '0;
			opt_s2_r <= '0;
		end else if (clk_en_i) begin
			din_s1_r <= din_pins_i;
			din_s2_r <= din_s1_r;
			opt_s1_r <= {enc_opt_i, pos_opt_i};
			opt_s2_r <= opt_s1_r;
		end
	end

	// state
	logic [FIS_PSET_W-1:0] hist_r [HIST_DEPTH];
	logic [FIS_PSET_W-1:0] hist_nxt [HIST_DEPTH];
	logic [FIS_DIN_W-1:0] din_r, din_nxt;
	logic [2:0] hsel_r, hsel_nxt, hact_r, hact_nxt;
	logic vsel_r, vsel_nxt, vact_r, vact_nxt;
	logic [FIS_IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
	logic [15:0] fcnt_r, fcnt_nxt;
	fis_bus_rsp_t rsp_r, rsp_nxt;
	logic irq_r, irq_nxt;
	logic busy_r, busy_nxt;

	// bitmap with unfitted option bits held low
	logic [FIS_DIN_W-1:0] din_live;
	always_comb begin
		din_live = '0;
		din_live[FIS_DIN_BASE_W-1:0] = din_s2_r[FIS_DIN_BASE_W-1:0];
		if (opt_s2_r[0]) begin
			din_live[FIS_DIN_POS_LSB +: FIS_DIN_POS_W] =
				din_s2_r[FIS_DIN_POS_LSB +: FIS_DIN_POS_W];
		end
		if (opt_s2_r[1]) begin
			din_live[FIS_DIN_ENC_BIT] = din_s2_r[FIS_DIN_ENC_BIT];
		end
	end

	logic acc, rd, wr;
	logic [31:0] rdata;
	always_comb begin
		acc = (bus_req_i.read || bus_req_i.write) && !busy_r;
		rd = acc && bus_req_i.read;
		wr = acc && bus_req_i.write;
		for (int i = 0; i < HIST_DEPTH; i++) begin
			hist_nxt[i] = hist_r[i];
		end
		din_nxt = din_live;
		hsel_nxt = hsel_r;
		hact_nxt = hact_r;
		vsel_nxt = vsel_r;
		vact_nxt = vact_r;
		mask_nxt = mask_r;
		stat_nxt = stat_r;
		fcnt_nxt = fcnt_r;
		busy_nxt = acc;
		rdata = FIS_RD_UNMAPPED;
		// fault capture and shift
		if (fault_i) begin
			for (int i = HIST_DEPTH - 1; i > 0; i--) begin
				hist_nxt[i] = hist_r[i-1];
			end
			hist_nxt[0] = pset_i;
			fcnt_nxt = fcnt_r + 16'h0001;
		end
		case (bus_req_i.address)
			FIS_OFS_HIST_SEL: rdata = {23'h00_0000, 1'b0, 5'h00, hact_r};
			FIS_OFS_HIST_DATA: rdata = {30'h0000_0000, hist_r[hact_r - 3'h1]};
			FIS_OFS_VER_SEL: rdata = {31'h0000_0000, vact_r};
			FIS_OFS_VER_DATA: rdata = vact_r ? {16'h0000, ver_clip(VERSION_1)}
				: {16'h0000, ver_clip(VERSION_0)};
			FIS_OFS_DIN: rdata = {19'h0_0000, din_r};
			FIS_OFS_IRQ_STAT: rdata = {30'h0000_0000, stat_r};
			FIS_OFS_IRQ_MASK: rdata = {30'h0000_0000, mask_r};
			FIS_OFS_FAULT_CNT: rdata = {16'h0000, fcnt_r};
			default: rdata = FIS_RD_UNMAPPED;
		endcase
		if (wr) begin
			case (bus_req_i.address)
				FIS_OFS_HIST_SEL: begin
					hsel_nxt = bus_req_i.writedata[FIS_SEL_IDX_LSB +: FIS_SEL_IDX_W];
					// selection takes effect only when confirmed and in range
					if (bus_req_i.writedata[FIS_SEL_CONFIRM_BIT]
						&& sel_ok(bus_req_i.writedata[2:0])) begin
						hact_nxt = bus_req_i.writedata[2:0];
					end
				end
				FIS_OFS_VER_SEL: begin
					vsel_nxt = bus_req_i.writedata[0];
					if (bus_req_i.writedata[FIS_SEL_CONFIRM_BIT]) begin
						vact_nxt = bus_req_i.writedata[0];
					end
				end
				FIS_OFS_IRQ_MASK: mask_nxt = bus_req_i.writedata[FIS_IRQ_W-1:0];
				default: ;
			endcase
		end
		if (rd && bus_req_i.address == FIS_OFS_IRQ_STAT) begin
			stat_nxt = '0;
		end
		// events win over the read clear
		if (fault_i) begin
			stat_nxt[FIS_IRQ_FAULT_BIT] = 1'b1;
		end
		if (din_live != din_r) begin
			stat_nxt[FIS_IRQ_DIN_BIT] = 1'b1;
		end
		rsp_nxt.waitrequest = !acc;
		rsp_nxt.readdatavalid = rd;
		rsp_nxt.readdata = rd ? rdata : rsp_r.readdata;
		irq_nxt = |(stat_nxt & mask_nxt);
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < HIST_DEPTH; i++) begin
				hist_r[i] <= '0;
			end
			din_r <= '0;
			hsel_r <= FIS_SEL_RST;
			hact_r <= FIS_SEL_RST;
			vsel_r <= 1'b0;
			vact_r <= 1'b0;
			stat_r <= '0;
			mask_r <= '0;
			fcnt_r <= '0;
			rsp_r <= '{readdata: 32'h0000_0000, waitrequest: 1'b1, readdatavalid: 1'b0};
			irq_r <= 1'b0;
			busy_r <= 1'b0;
		end else if (clk_en_i) begin
			for (int i = 0; i < HIST_DEPTH; i++) begin
				hist_r[i] <= hist_nxt[i];
			end
			din_r <= din_nxt;
			hsel_r <= hsel_nxt;
			hact_r <= hact_nxt;
			vsel_r <= vsel_nxt;
			vact_r <= vact_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			fcnt_r <= fcnt_nxt;
			rsp_r <= rsp_nxt;
			irq_r <= irq_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign bus_rsp_o = rsp_r;
	assign irq_o = irq_r;

	// assertions
	chk_hist_newest: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && fault_i |=> hist_r[0] == $past(pset_i))
		else $error("newest history entry not captured");
	chk_hist_shift: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && fault_i |=> hist_r[HIST_DEPTH-1] == $past(hist_r[HIST_DEPTH-2]))
		else $error("history not shifted");
	chk_hist_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && !fault_i |=> hist_r[HIST_DEPTH-1] == $past(hist_r[HIST_DEPTH-1]))
		else $error("history changed without fault");
	chk_sel_range: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		hact_r >= 3'h1 && 32'(hact_r) <= HIST_DEPTH)
		else $error("active history index out of range");
	chk_ver_range: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rsp_r.readdatavalid && $past(bus_req_i.address) == FIS_OFS_VER_DATA
		|-> rsp_r.readdata <= VER_MAX32)
		else $error("version out of range");
	chk_din_base: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && $past(clk_en_i) |=> din_r[5:0] == $past(din_s2_r[5:0]))
		else $error("base input bits wrong");
	chk_din_pos: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && !opt_s2_r[0] |=> din_r[11:6] == 6'h00)
		else $error("positioning bits set without option");
	chk_din_enc: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && !opt_s2_r[1] |=> !din_r[FIS_DIN_ENC_BIT])
		else $error("encoder bit set without option");
	chk_din_basic: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!opt_s2_r[0] && !opt_s2_r[1] && clk_en_i ##1 clk_en_i |-> din_r <= 13'h003F)
		else $error("basic bitmap above 3f");
	chk_irq_level: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		irq_r == |(stat_r & mask_r))
		else $error("irq does not follow status and mask");

	// selector staging and confirm
	chk_hsel_store: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && wr && bus_req_i.address == FIS_OFS_HIST_SEL
		|=> hsel_r == $past(bus_req_i.writedata[2:0]))
		else $error("history selector not stored");

	chk_sel_unconf: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && wr && bus_req_i.address == FIS_OFS_HIST_SEL
		&& !bus_req_i.writedata[FIS_SEL_CONFIRM_BIT] |=> hact_r == $past(hact_r))
		else $error("unconfirmed selection applied");

	chk_sel_apply: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && wr && bus_req_i.address == FIS_OFS_HIST_SEL
		&& bus_req_i.writedata[FIS_SEL_CONFIRM_BIT] && bus_req_i.writedata[2:0] >= 3'h1
		&& 32'(bus_req_i.writedata[2:0]) <= HIST_DEPTH
		|=> hact_r == $past(bus_req_i.writedata[2:0]))
		else $error("confirmed selection not applied");

	chk_vsel_store: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && wr && bus_req_i.address == FIS_OFS_VER_SEL
		|=> vsel_r == $past(bus_req_i.writedata[0]))
		else $error("version selector not stored");

	chk_vact_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && !(wr && bus_req_i.address == FIS_OFS_VER_SEL)
		|=> vact_r == $past(vact_r))
		else $error("version entry changed without selection");

	// bus answer timing
	chk_wait_pulse: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && !rsp_r.waitrequest |=> rsp_r.waitrequest)
		else $error("waitrequest low for more than one cycle");

	chk_wait_answer: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && (bus_req_i.read || bus_req_i.write) && !busy_r
		|=> !rsp_r.waitrequest)
		else $error("accepted access not answered");

	chk_rdv_read: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rsp_r.readdatavalid |-> !rsp_r.waitrequest)
		else $error("read data valid outside answer");

	// status, counter and history
	chk_fault_status: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && fault_i |=> stat_r[FIS_IRQ_FAULT_BIT])
		else $error("fault status not set");

	chk_din_status: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && din_live != din_r |=> stat_r[FIS_IRQ_DIN_BIT])
		else $error("input change status not set");

	chk_stat_clear: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && rd && bus_req_i.address == FIS_OFS_IRQ_STAT && !fault_i
		|=> !stat_r[FIS_IRQ_FAULT_BIT])
		else $error("status not cleared by read");

	chk_fcnt_step: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && fault_i |=> fcnt_r == $past(fcnt_r) + 16'h0001)
		else $error("fault counter not stepped");

	chk_hist_second: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && fault_i |=> hist_r[1] == $past(hist_r[0]))
		else $error("second history entry not shifted");

	chk_hist_read: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && $past(clk_en_i) && rsp_r.readdatavalid
		&& $past(bus_req_i.address) == FIS_OFS_HIST_DATA
		|-> rsp_r.readdata[31:FIS_PSET_W] == '0)
		else $error("history read has upper bits set");

	// option bits pass through when fitted
	chk_din_pos_on: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && opt_s2_r[0] |=> din_r[11:6] == $past(din_s2_r[11:6]))
		else $error("positioning bits not reported");

	chk_din_enc_on: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		clk_en_i && opt_s2_r[1] |=> din_r[FIS_DIN_ENC_BIT] == $past(din_s2_r[FIS_DIN_ENC_BIT]))
		else $error("encoder bit not reported");

	// clock enable low freezes state
	chk_freeze_hist: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!clk_en_i |=> hist_r[0] == $past(hist_r[0]) && fcnt_r == $past(fcnt_r))
		else $error("history moved while frozen");

	chk_freeze_bus: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!clk_en_i |=> rsp_r == $past(rsp_r))
		else $error("bus answer moved while frozen");
endmodule

// ==== fis_keypad.sv ====
// keypad model: avalon-mm master that reads and selects bank entries
`timescale 1ns/1ns
module fis_keypad
	import fis_pkg::*;
(
	input wire logic clk_sys_i, // system clock
	input wire fis_bus_rsp_t bus_rsp_i, // slave answer
	output fis_bus_req_t bus_req_o // master request
);
	initial bus_req_o = '0;

	// one access, held until waitrequest is seen low
	task automatic acc(input logic wr, input logic [5:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk_sys_i);
		bus_req_o <= '{read: !wr, write: wr, address: adr, writedata: wd};
		do @(posedge clk_sys_i); while (bus_rsp_i.waitrequest !== 1'b0);
		rd = bus_rsp_i.readdata;
		// released lines show no stale value
		bus_req_o <= '{read: 1'b0, write: 1'b0, address: ~adr, writedata: ~wd};
	endtask

	// pick an index, then confirm it
	task automatic sel(input logic [5:0] adr, input logic [2:0] idx);
		logic [31:0] d;
		acc(1'b1, adr, 32'(idx), d);
		acc(1'b1, adr, 32'h0000_0100 | 32'(idx), d);
	endtask
endmodule

// ==== fis_bank_test.sv ====
// self-checking bench of the fault info / input status bank
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module fis_bank_test
	import fis_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic clk_en_i = 1'b1;
	logic fault_i = 1'b0;
	logic [1:0] pset_i = 2'h0;
	logic [12:0] din_pins_i = 13'h0000;
	logic pos_opt_i = 1'b0;
	logic enc_opt_i = 1'b0;
	logic irq_o;
	fis_bus_req_t bus_req;
	fis_bus_rsp_t bus_rsp;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [1:0] hist [1:5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0};

	always #20 clk_sys_i = ~clk_sys_i;

	fis_bank #(.VERSION_0(16'h0123), .VERSION_1(16'h270F)) u_fis_bank (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
		.bus_req_i(bus_req), .bus_rsp_o(bus_rsp), .fault_i(fault_i), .pset_i(pset_i),
		.din_pins_i(din_pins_i), .pos_opt_i(pos_opt_i), .enc_opt_i(enc_opt_i), .irq_o(irq_o));
	fis_keypad u_fis_keypad (.clk_sys_i(clk_sys_i), .bus_rsp_i(bus_rsp), .bus_req_o(bus_req));

	task automatic rd(input logic [5:0] adr, input logic [31:0] exp);
		logic [31:0] d;
		u_fis_keypad.acc(1'b0, adr, 32'h0000_0000, d);
		`CHK(d, exp)
	endtask
	task automatic wr(input logic [5:0] adr, input logic [31:0] wd);
		logic [31:0] d;
		u_fis_keypad.acc(1'b1, adr, wd, d);
	endtask
	// one-cycle fault pulse; expected history shifts down
	task automatic fault(input logic [1:0] code);
		@(posedge clk_sys_i);
		fault_i <= 1'b1;
		pset_i <= code;
		for (int i = 5; i > 1; i--) begin
			hist[i] = hist[i-1];
		end
		hist[1] = code;
		@(posedge clk_sys_i);
		fault_i <= 1'b0;
	endtask
	task automatic din(input logic [12:0] p, input logic po, input logic eo,
		input logic [31:0] exp);
		@(posedge clk_sys_i);
		din_pins_i <= p;
		pos_opt_i <= po;
		enc_opt_i <= eo;
		repeat (6) @(posedge clk_sys_i);
		rd(FIS_OFS_DIN, exp);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			end_of_test();
		end
	end

	initial begin
		repeat (16) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		rd(FIS_OFS_HIST_DATA, 32'h0000_0000);
		fault(2'h1);
		fault(2'h2);
		fault(2'h3);
		fault(2'h0);
		fault(2'h2);
		fault(2'h3);
		for (int i = 1; i <= 5; i++) begin
			u_fis_keypad.sel(FIS_OFS_HIST_SEL, 3'(i));
			rd(FIS_OFS_HIST_DATA, 32'(hist[i]));
		end
		wr(FIS_OFS_HIST_SEL, 32'h0000_0002);
		rd(FIS_OFS_HIST_SEL, 32'h0000_0005);
		u_fis_keypad.sel(FIS_OFS_HIST_SEL, 3'h6);
		rd(FIS_OFS_HIST_SEL, 32'h0000_0005);
		rd(FIS_OFS_FAULT_CNT, 32'h0000_0006);
		u_fis_keypad.sel(FIS_OFS_VER_SEL, 3'h0);
		wr(FIS_OFS_VER_DATA, 32'h0000_0005);
		rd(FIS_OFS_VER_DATA, 32'h0000_0123);
		u_fis_keypad.sel(FIS_OFS_VER_SEL, 3'h1);
		rd(FIS_OFS_VER_DATA, 32'h0000_270F);
		din(13'h1FFF, 1'b0, 1'b0, 32'h0000_003F);
		din(13'h1FFF, 1'b1, 1'b0, 32'h0000_0FFF);
		din(13'h1555, 1'b1, 1'b1, 32'h0000_1555);
		din(13'h0AAA, 1'b0, 1'b1, 32'h0000_002A);
		rd(FIS_OFS_IRQ_STAT, 32'h0000_0003);
		rd(FIS_OFS_IRQ_STAT, 32'h0000_0000);
		wr(FIS_OFS_IRQ_MASK, 32'h0000_0001);
		`CHK(irq_o, 1'b0)
		fault(2'h1);
		repeat (3) @(posedge clk_sys_i);
		`CHK(irq_o, 1'b1)
		rd(FIS_OFS_IRQ_STAT, 32'h0000_0001);
		repeat (3) @(posedge clk_sys_i);
		`CHK(irq_o, 1'b0)
		wr(FIS_OFS_IRQ_MASK, 32'h0000_0000);
		fault(2'h2);
		repeat (3) @(posedge clk_sys_i);
		`CHK(irq_o, 1'b0)
		u_fis_keypad.sel(FIS_OFS_HIST_SEL, 3'h1);
		rd(FIS_OFS_HIST_DATA, 32'h0000_0002);
		rd(6'h20, 32'h0000_0000);
		rd(FIS_OFS_IRQ_MASK, 32'h0000_0000);
		rd(FIS_OFS_VER_SEL, 32'h0000_0001);
		@(posedge clk_sys_i);
		clk_en_i <= 1'b0;
		fault(2'h3);
		clk_en_i <= 1'b1;
		rd(FIS_OFS_FAULT_CNT, 32'h0000_0008);
		rd(FIS_OFS_HIST_DATA, 32'h0000_0002);
		end_of_test();
	end
endmodule
